// File: rtl/cdmd_decoder.sv
// Data memory decoder and machine cycle framing for the core
`timescale 1ns/10ps
`default_nettype none
`include "cdmd_params.svh"
module cdmd_decoder
  import cdmd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Request from the execute logic
  input wire cdmd_req_t req,
  input wire logic instr_done,
  input wire logic [7:0] pointer_reg_zero,
  input wire logic [7:0] pointer_reg_one,
  input wire logic [7:0] extended_page_select,
  input wire logic [15:0] fetch_addr,
  // Cycle framing
  output logic [2:0] state_idx,
  output logic cycle_end,
  output logic instr_retire,
  // Decoded access
  output cdmd_sel_t sel,
  output logic [7:0] internal_byte_addr,
  output logic [15:0] extended_addr,
  output logic ext_peripheral,
  output logic [4:0] ext_region,
  output logic ext_ram_invalid,
  output logic access_write,
  output logic [7:0] access_wdata,
  output logic rom_fetch_hit
);

  //--------------------------------------------------------------
  // Machine cycle framing
  //--------------------------------------------------------------
  logic [2:0] state;
  logic [2:0] next_state;
  logic retire_pending;
  wire last_state = (state == `CDMD_LAST_STATE);

  // Six states per machine cycle, one per clock
  assign next_state = last_state ? 3'd0 : state + 3'd1;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= 3'd0;
    end else begin
      state <= next_state;
    end
  end

  // Completion is held until the cycle boundary so no instruction
  // can finish mid-cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      retire_pending <= 1'b0;
    end else if (last_state) begin
      retire_pending <= 1'b0;
    end else if (instr_done) begin
      retire_pending <= 1'b1;
    end
  end
  // Framing outputs decode the state register combinationally, with no added register delay
  assign state_idx = state;
  assign cycle_end = last_state;
  assign instr_retire = last_state && (retire_pending || instr_done);

  //--------------------------------------------------------------
  // Address selection
  //--------------------------------------------------------------
  wire is_direct = (req.mode == CDMD_MODE_DIRECT);
  wire is_indirect = (req.mode == CDMD_MODE_INDIRECT);
  wire is_ext = req.mode[1];
  wire [7:0] pointer_val = req.ptr_sel ? pointer_reg_one : pointer_reg_zero;
  // Direct takes the instruction field, indirect the pointer
  wire [7:0] next_ibyte = is_direct ? req.direct_addr : pointer_val;
  // Paged path splices page select over the pointer byte
  wire [15:0] next_ext = (req.mode == CDMD_MODE_EXT_PAGED) ?
    {extended_page_select, pointer_val} : req.ext_ptr;
  wire upper_half = next_ibyte[`CDMD_UPPER_BIT];

  // Target decode: one-hot by construction since each term excludes
  // the others by mode and address bit
  wire hit_lower = req.valid && !is_ext && !upper_half;
  wire hit_upper = req.valid && is_indirect && upper_half;
  wire hit_sfr = req.valid && is_direct && upper_half;
  wire hit_ext = req.valid && is_ext;
  // Packed order is lower, upper, sfr, ext from the top bit down
  cdmd_sel_t next_sel;
  assign next_sel = {hit_lower, hit_upper, hit_sfr, hit_ext};
  wire next_peri = (next_ext >= `CDMD_PERI_BASE) &&
    (next_ext <= `CDMD_PERI_END);
  // Flag only, software is trusted to stay in range
  wire next_bad = !next_peri && (next_ext > `CDMD_RAM_VALID_END);

  // Registered decode outputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sel <= '0;
      internal_byte_addr <= 8'h00;
      extended_addr <= 16'h0000;
      ext_peripheral <= 1'b0;
      ext_region <= 5'h00;
      ext_ram_invalid <= 1'b0;
      access_write <= 1'b0;
      access_wdata <= 8'h00;
      rom_fetch_hit <= 1'b0;
    end else begin
      sel <= next_sel;
      internal_byte_addr <= next_ibyte;
      extended_addr <= next_ext;
      ext_peripheral <= next_sel.ext && next_peri;
      ext_region <= next_ext[12:8];
      ext_ram_invalid <= next_sel.ext && next_bad;
      access_write <= req.valid && req.write;
      access_wdata <= req.wdata;
      rom_fetch_hit <= (fetch_addr <= `CDMD_ROM_END);
    end
  end

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  state_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    last_state |=> state == 3'd0 ##5 last_state)
    else $error("machine cycle is not six states");
  state_range_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state < `CDMD_NUM_STATES)
    else $error("state index out of range");
  retire_edge_a: assert property (@(posedge core_clk) disable iff (!nrst)
    instr_retire |-> state == 3'd5)
    else $error("instruction retired mid cycle");
  sel_onehot_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid |=> $onehot(sel))
    else $error("target select not one hot");
  sfr_route_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && is_direct && req.direct_addr[7] |=> sel.sfr)
    else $error("direct upper access missed sfr");
  upper_route_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && is_indirect && pointer_val[7] |=> sel.upper_ram
      && !sel.sfr)
    else $error("indirect upper access missed upper ram");
  lower_route_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && !is_ext && !next_ibyte[7] |=> sel.lower_ram)
    else $error("low address missed lower ram");
  paged_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && req.mode == CDMD_MODE_EXT_PAGED |=>
      extended_addr == {$past(extended_page_select),
      $past(pointer_val)})
    else $error("paged address wrong");
  peri_route_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ext_peripheral |-> extended_addr[15:13] == 3'b011)
    else $error("peripheral flag outside window");
  direct_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && is_direct |=> internal_byte_addr ==
      $past(req.direct_addr))
    else $error("direct address not from instruction");
  rom_hit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    fetch_addr > `CDMD_ROM_END |=> !rom_fetch_hit)
    else $error("fetch beyond rom flagged as hit");

  // Reset clears the framing and the selects on the next edge; this
  // check must see reset, so it has no reset guard of its own
  reset_clear_a: assert property (@(posedge core_clk)
    !nrst |=> state == 3'd0 && sel == '0 && !instr_retire)
    else $error("reset did not clear framing and selects");
  // Framing advances exactly one state per clock between wraps
  state_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !last_state |=> state == $past(state) + 3'd1)
    else $error("machine cycle state skipped or stalled");
  // A completion seen before S6 still retires at the next boundary
  retire_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    instr_done && !last_state |-> ##[1:5] instr_retire)
    else $error("completed instruction never retired");

  // Indirect accesses take the pointer byte, never the instruction field
  indirect_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && is_indirect |=> internal_byte_addr ==
      $past(pointer_val))
    else $error("indirect address not from pointer");
  // Idle cycles select nothing, so no target drives read data
  idle_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !req.valid |=> sel == '0)
    else $error("target selected without a request");

  // Pointer mode passes all sixteen bits to the extended space
  ext_ptr_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && req.mode == CDMD_MODE_EXT_PTR |=> sel.ext &&
      extended_addr == $past(req.ext_ptr))
    else $error("pointer mode extended access misrouted");
  // Every address in the peripheral window raises the flag and region
  peri_hit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && is_ext && next_ext[15:13] == 3'b011 |=>
      ext_peripheral && ext_region == $past(next_ext[12:8]))
    else $error("peripheral window access not flagged");
  // The invalid flag is advisory: it never drops the extended select
  ram_invalid_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ext_ram_invalid |-> sel.ext && !ext_peripheral &&
      extended_addr > `CDMD_RAM_VALID_END)
    else $error("invalid ram flag raised inside valid range");
  // Fetches inside the program store are always served
  rom_in_a: assert property (@(posedge core_clk) disable iff (!nrst)
    fetch_addr <= `CDMD_ROM_END |=> rom_fetch_hit)
    else $error("fetch inside rom not flagged");

  // Write strobe and data follow the request one cycle later
  write_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid && req.write |=> access_write)
    else $error("write request not flagged");
  wdata_pass_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid |=> access_wdata == $past(req.wdata))
    else $error("write data not carried");

  // Main scenarios the bench is expected to reach
  cov_sfr_c: cover property (@(posedge core_clk) sel.sfr);
  cov_upper_c: cover property (@(posedge core_clk) sel.upper_ram);
  cov_peri_c: cover property (@(posedge core_clk) ext_peripheral);
  cov_retire_c: cover property (@(posedge core_clk) instr_retire);
  cov_inval_c: cover property (@(posedge core_clk) ext_ram_invalid);

endmodule : cdmd_decoder
`default_nettype wire

// File: rtl/cdmd_params.svh
// Constants for the core data memory decoder
// Behaviour
// - Machine cycle has six states S1..S6, one per core clock.
// - Every instruction spans one or more whole machine cycles.
// - Internal byte space, extended data space and program space are distinct.
// - Internal space holds 128 lower RAM, 128 upper RAM, 128 SFR bytes.
// - Direct mode takes the address from the instruction's 8-bit field.
// - Indirect mode takes the address from the named pointer register.
// - Direct access at 80h..FFh goes to the SFR space.
// - Indirect access at 80h..FFh goes to upper RAM, never SFRs.
// - Access at 00h..7Fh goes to lower RAM in either mode.
// - Extended data space is one 64 KB bank, 16-bit addresses.
// - Extended 6000h..7FFFh selects peripherals, 32 regions; RAM is valid only at 0000h..02FFh.
// - Paged access: page select is upper byte, pointer register lower byte.
// - Program fetches 0000h..9FFFh are served from on-chip ROM.
`ifndef CDMD_PARAMS_SVH
`define CDMD_PARAMS_SVH
`define CDMD_NUM_STATES 3'd6
`define CDMD_LAST_STATE 3'd5
`define CDMD_UPPER_BIT 7
`define CDMD_PERI_BASE 16'h6000
`define CDMD_PERI_END 16'h7fff
`define CDMD_RAM_VALID_END 16'h02ff
`define CDMD_ROM_END 16'h9fff
`endif

// File: rtl/cdmd_pkg.sv
// Types shared by the core data memory decoder
package cdmd_pkg;
  typedef enum logic [1:0] {
    CDMD_MODE_DIRECT = 2'b00,
    CDMD_MODE_INDIRECT = 2'b01,
    CDMD_MODE_EXT_PTR = 2'b10,
    CDMD_MODE_EXT_PAGED = 2'b11
  } cdmd_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    cdmd_mode_t mode;
    logic ptr_sel;
    logic [7:0] direct_addr;
    logic [15:0] ext_ptr;
    logic [7:0] wdata;
  } cdmd_req_t;

  typedef struct packed {
    logic lower_ram;
    logic upper_ram;
    logic sfr;
    logic ext;
  } cdmd_sel_t;
endpackage : cdmd_pkg

// File: testbench/cdmd_decoder_tb.sv
// Bench for the core data memory decoder
`timescale 1ns/10ps
`default_nettype none
module cdmd_decoder_tb;
  import cdmd_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  cdmd_req_t req = '0;
  logic [15:0] fa = 16'h0000;
  logic [7:0] p0 = 8'h80, p1 = 8'h7f, pg = 8'h61;
  logic fin = 1'b0;
  logic done, ce, ret, per, inv, wr, rom;
  logic [7:0] r0, r1, xp, ia, wd;
  logic [2:0] st;
  cdmd_sel_t sel;
  logic [15:0] xa;
  logic [4:0] rg;
  int n_errors = 0;
  int checks_done = 0;
  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;
  cdmd_exec_model model (.core_clk(core_clk), .nrst(nrst), .set_p0(p0),
    .set_p1(p1), .set_pg(pg), .finish(fin), .pointer_reg_zero(r0),
    .pointer_reg_one(r1), .extended_page_select(xp), .instr_done(done));
  cdmd_decoder dut (.core_clk(core_clk), .nrst(nrst), .req(req),
    .instr_done(done), .pointer_reg_zero(r0), .pointer_reg_one(r1),
    .extended_page_select(xp), .fetch_addr(fa), .state_idx(st),
    .cycle_end(ce), .instr_retire(ret), .sel(sel),
    .internal_byte_addr(ia), .extended_addr(xa), .ext_peripheral(per),
    .ext_region(rg), .ext_ram_invalid(inv), .access_write(wr),
    .access_wdata(wd), .rom_fetch_hit(rom));
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One access from a falling edge, judged one cycle on; back to back
  task automatic acc(input cdmd_mode_t m, input logic ps, logic [15:0] a);
    logic [7:0] ea;
    logic [15:0] xe;
    logic ext, pe;
    ext = m[1];
    ea = m == CDMD_MODE_DIRECT ? a[7:0] : (ps ? p1 : p0);
    xe = m == CDMD_MODE_EXT_PAGED ? {pg, ea} : a;
    pe = xe[15:13] == 3'b011;
    fa <= a;
    req <= '{1'b1, ps, m, ps, m == CDMD_MODE_DIRECT ? a[7:0] : ~ea, a,
      a[7:0] ^ 8'ha5};
    @(negedge core_clk);
    chk(sel, {!ext && !ea[7], !ext && ea[7] && m[0],
      !ext && ea[7] && !m[0], ext});
    chk(rom, a <= 16'h9fff);
    chk(wr, ps);
    chk(wd, a[7:0] ^ 8'ha5);
    if (!ext) chk(ia, ea);
    else chk(xa, xe);
    if (ext) chk({per, rg, inv}, {pe, xe[12:8], xe > 16'h02ff && !pe});
  endtask : acc
  task automatic t_internal();
    acc(CDMD_MODE_DIRECT, 1'b0, 16'h0000);
    acc(CDMD_MODE_DIRECT, 1'b0, 16'h007f);
    acc(CDMD_MODE_DIRECT, 1'b1, 16'h0080);
    acc(CDMD_MODE_DIRECT, 1'b0, 16'h00ff);
    acc(CDMD_MODE_INDIRECT, 1'b0, 16'h0000);
    acc(CDMD_MODE_INDIRECT, 1'b1, 16'h0000);
  endtask : t_internal
  task automatic t_extended();
    logic [15:0] xv [8] = '{16'h02ff, 16'h0300, 16'h5fff, 16'h6000,
      16'h7fff, 16'h8000, 16'h9fff, 16'ha000};
    foreach (xv[i]) acc(CDMD_MODE_EXT_PTR, i[0], xv[i]);
    acc(CDMD_MODE_EXT_PAGED, 1'b0, 16'h0000);
    acc(CDMD_MODE_EXT_PAGED, 1'b1, 16'h0000);
    req.valid <= 1'b0;
    @(negedge core_clk);
    chk(sel, 16'h0000);
  endtask : t_extended
  // Two machine cycles, the first one retiring an instruction
  task automatic t_frame();
    int k;
    for (k = 0; k < 7 && st !== 3'd5; k++) @(negedge core_clk);
    for (k = 0; k < 12; k++) begin
      @(negedge core_clk);
      fin <= k == 0;
      chk(st, k % 6);
      chk(ce, k % 6 == 5);
      chk(ret, k == 5);
    end
  endtask : t_frame
  // Mid-run reset with a request standing: reset wins, then the framing
  // restarts at S1 and the standing request is taken at the first edge
  task automatic t_reset();
    int k;
    req <= '{1'b1, 1'b1, CDMD_MODE_EXT_PTR, 1'b0, 8'h00, 16'h6000, 8'h3c};
    @(negedge core_clk);
    chk({sel, per}, 5'h03);
    nrst <= 1'b0;
    for (k = 0; k < 3; k++) begin
      @(negedge core_clk);
      chk({sel, per, inv, wr, rom, ce, ret, st}, 13'h0000);
      chk({ia, wd}, 16'h0000);
      chk(xa, 16'h0000);
      chk(rg, 5'h00);
    end
    nrst <= 1'b1;
    for (k = 1; k < 3; k++) begin
      @(negedge core_clk);
      chk(st, k);
      chk({sel, per}, 5'h03);
      chk(xa, 16'h6000);
    end
    req.valid <= 1'b0;
  endtask : t_reset
  initial begin
    repeat (10) @(negedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(negedge core_clk);
    t_internal();
    t_extended();
    t_frame();
    t_reset();
    wrap_up();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
endmodule : cdmd_decoder_tb
`default_nettype wire

// File: testbench/cdmd_exec_model.sv
// Execute-side model feeding pointers, page and completion
`timescale 1ns/10ps
`default_nettype none
module cdmd_exec_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Values set by the bench
  input wire logic [7:0] set_p0,
  input wire logic [7:0] set_p1,
  input wire logic [7:0] set_pg,
  input wire logic finish,
  // Toward the decoder
  output logic [7:0] pointer_reg_zero,
  output logic [7:0] pointer_reg_one,
  output logic [7:0] extended_page_select,
  output logic instr_done
);
  // Falling edge updates keep clear of the decoder's sampling edge
  always_ff @(negedge core_clk) begin
    pointer_reg_zero <= nrst ? set_p0 : 8'h00;
    pointer_reg_one <= nrst ? set_p1 : 8'h00;
    extended_page_select <= nrst ? set_pg : 8'h00;
    instr_done <= nrst & finish;
  end
endmodule : cdmd_exec_model
`default_nettype wire
